// >>> rtl/uart_rx_fc_defs.vh
// Constants for the receive holding path and flow control logic.
// Assumes inclusion by bare name from the design files only.
`ifndef UART_RX_FC_DEFS_VH
`define UART_RX_FC_DEFS_VH

// Receive buffer geometry
`define FIFO_DEPTH 64
`define FIFO_AW 6
`define FIFO_CW 7
`define ENTRY_W 11
`define TAG_W 3

// Control bit positions
`define FCR_FIFO_EN 0
`define MCR_RTS 1
`define LCR_WLEN_LO 0
`define EFR_ENH 4
`define EFR_SCD 5
`define EFR_ARTS 6
`define EFR_ACTS 7
`define IER_XOFF 5
`define IER_RTS 6
`define IER_CTS 7
`define EXTRA_FEATURE_CTRL_REG_MDROP 0
`define EXTRA_FEATURE_CTRL_REG_485 4
`define EXTRA_FEATURE_CTRL_REG_485INV 5

// Trigger levels count in groups of four characters
`define LEVEL_SHIFT 2

// Software flow mode encoding, per direction
`define SW_NONE 2'h0
`define SW_CH1 2'h1
`define SW_CH2 2'h2
`define SW_BOTH 2'h3

// Flow character register indices
`define CH_RESUME1 2'h0
`define CH_RESUME2 2'h1
`define CH_PAUSE1 2'h2
`define CH_PAUSE2 2'h3
`define CHAR_RESET 8'h00

// Flow character sender states, one-hot
`define ST_IDLE 3'h1
`define ST_FIRST 3'h2
`define ST_SECOND 3'h4

`endif

// >>> rtl/rx_fifo64.v
// Receive buffer: 64 entries of data byte plus error tags.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_fc_defs.vh"

module rx_fifo64 (
	input wire i_clk,
	input wire i_srst,
	input wire i_push,
	input wire [`ENTRY_W-1:0] i_data,
	input wire i_pop,
	output wire [`ENTRY_W-1:0] o_head,
	output wire [`FIFO_CW-1:0] o_count,
	output wire o_full
);
	reg [`ENTRY_W-1:0] mem [0:`FIFO_DEPTH-1];
	reg [`FIFO_AW-1:0] wr_ptr_reg;
	reg [`FIFO_AW-1:0] rd_ptr_reg;
	reg [`FIFO_CW-1:0] count_reg;

	// Storage, one entry per push
	always @(posedge i_clk) begin
		if (i_push)
			mem[wr_ptr_reg] <= i_data;
	end

	always @(posedge i_clk) begin
		if (i_srst) begin
			wr_ptr_reg <= {`FIFO_AW{1'b0}};
			rd_ptr_reg <= {`FIFO_AW{1'b0}};
			count_reg <= {`FIFO_CW{1'b0}};
		end else begin
			if (i_push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (i_pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (i_push && !i_pop)
				count_reg <= count_reg + 1'b1;
			else if (i_pop && !i_push)
				count_reg <= count_reg - 1'b1;
		end
	end

	// Oldest entry always on view
	assign o_head = mem[rd_ptr_reg];
	assign o_count = count_reg;
	assign o_full = (count_reg == `FIFO_DEPTH);
endmodule // rx_fifo64

`default_nettype wire

// >>> rtl/uart_rx_flow_control.v
// Receive holding path, hardware and software flow control,
// special character detect, RS-485 direction and multidrop filter.
// Assumes received characters arrive at least two clocks apart and
// the transmitter pulses I_TX_CHAR_DONE after each stop bit.
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_fc_defs.vh"

// Notes on behaviour
// - Buffer holds 64 entries of byte plus tags
// - Holding output shows oldest buffered character
// - Read advances and refreshes status error tags
// - RTS rising edge sets flag, interrupts
// - RTS goes high at halt level
// - RTS returns low at resume level
// - Keep storing characters while RTS high
// - CTS high stops transmitter after current character
// - CTS going high sets flag, interrupts
// - Match off characters, halt after current character
// - Off match flags; on match resumes, clears
// - Reset clears four flow characters to zero
// - Double mode pairs characters; matches never stored
// - Send off/on characters at halt/resume levels
// - Special character stored and flagged
// - Comparisons use selected word length only
// - RS-485 direction idles high, low while sending
// - Extra feature bit inverts direction polarity
// - Multidrop when enabled without special detect
// - Disabled multidrop receiver drops data, keeps addresses
module uart_rx_flow_control (
	input wire I_CLK,
	input wire I_SRST,
	input wire I_RX_VALID,
	input wire [7:0] I_RX_DATA,
	input wire I_RX_PARITY_BIT,
	input wire [2:0] I_RX_ERR,
	input wire I_RX_ENABLE,
	input wire I_RHR_READ,
	input wire I_ISR_READ,
	input wire [7:0] I_FIFO_CONTROL_REG,
	input wire [7:0] I_ENHANCED_FEATURE_REG,
	input wire [7:0] I_EXTRA_FEATURE_CTRL_REG,
	input wire [7:0] I_MODEM_CONTROL_REG,
	input wire [7:0] I_INTERRUPT_ENABLE_REG,
	input wire [7:0] I_TRIGGER_CONTROL_REG,
	input wire [7:0] I_LINE_CONTROL_REG,
	input wire [3:0] I_SWFC_MODE,
	input wire I_CHAR_WE,
	input wire [1:0] I_CHAR_SEL,
	input wire [7:0] I_CHAR_WDATA,
	input wire I_CTS_N,
	input wire I_TX_PENDING,
	input wire I_TX_CHAR_DONE,
	input wire I_TX_FC_ACK,
	output reg [7:0] O_RX_HOLDING_REG,
	output reg [2:0] O_LINE_STATUS_ERR,
	output reg O_DATA_READY,
	output reg [6:0] O_RX_LEVEL,
	output reg O_RTS_N,
	output reg O_TX_ALLOW,
	output reg O_TX_FC_REQ,
	output reg [7:0] O_TX_FC_CHAR,
	output reg O_ISR_FLOW,
	output reg O_ISR_XOFF,
	output reg O_IRQ
);
	// Masked comparison at the selected word length
	function char_match;
		input [7:0] a;
		input [7:0] b;
		input [1:0] wl;
		reg [7:0] m;
		begin
			m = 8'hff >> (2'h3 - wl);
			char_match = ((a ^ b) & m) == 8'h00;
		end
	endfunction

	wire [7:0] enhanced_feature_reg = I_ENHANCED_FEATURE_REG;
	wire [7:0] extra_feature_ctrl_reg = I_EXTRA_FEATURE_CTRL_REG;
	wire [7:0] interrupt_enable_reg = I_INTERRUPT_ENABLE_REG;
	wire [1:0] wlen = I_LINE_CONTROL_REG[`LCR_WLEN_LO+1:`LCR_WLEN_LO];
	wire [1:0] rx_mode = I_SWFC_MODE[1:0];
	wire [1:0] tx_mode = I_SWFC_MODE[3:2];
	wire fifo_en = I_FIFO_CONTROL_REG[`FCR_FIFO_EN];

	// Flow control characters
	reg [7:0] char_reg [0:3];
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_char
			always @(posedge I_CLK) begin
				if (I_SRST)
					char_reg[gi] <= `CHAR_RESET;
				else if (I_CHAR_WE && I_CHAR_SEL == gi)
					char_reg[gi] <= I_CHAR_WDATA;
			end
		end
	endgenerate

	wire [7:0] resume1 = char_reg[`CH_RESUME1];
	wire [7:0] resume2 = char_reg[`CH_RESUME2];
	wire [7:0] pause1 = char_reg[`CH_PAUSE1];
	wire [7:0] pause2 = char_reg[`CH_PAUSE2];

	// Receive buffer
	wire [`ENTRY_W-1:0] head;
	wire [`FIFO_CW-1:0] count;
	wire full;
	reg push;
	reg [`ENTRY_W-1:0] push_data;
	wire pop = I_RHR_READ && (count != {`FIFO_CW{1'b0}});
	wire room = fifo_en ? !full : (count == {`FIFO_CW{1'b0}});

	rx_fifo64 u_fifo (
		.i_clk(I_CLK),
		.i_srst(I_SRST),
		.i_push(push),
		.i_data(push_data),
		.i_pop(pop),
		.o_head(head),
		.o_count(count),
		.o_full(full)
	);

	wire [6:0] halt_lvl = {1'b0, I_TRIGGER_CONTROL_REG[3:0], 2'b00};
	wire [6:0] resume_lvl = {1'b0, I_TRIGGER_CONTROL_REG[7:4], 2'b00};
	wire at_halt = count >= halt_lvl;
	wire at_resume = count <= resume_lvl;

	// Receive filtering and flow character matching
	wire mdrop = extra_feature_ctrl_reg[`EXTRA_FEATURE_CTRL_REG_MDROP] && !enhanced_feature_reg[`EFR_SCD];
	wire accept = I_RX_VALID &&
		(I_RX_ENABLE || (mdrop && I_RX_PARITY_BIT));
	wire [2:0] tag = {I_RX_ERR[2:1],
		I_RX_ERR[0] | (mdrop & I_RX_PARITY_BIT)};
	wire [`ENTRY_W-1:0] rx_entry = {tag, I_RX_DATA};
	wire scd_hit = enhanced_feature_reg[`EFR_SCD] && char_match(I_RX_DATA, pause2, wlen);
	wire sw_rx = (rx_mode != `SW_NONE) && !scd_hit;
	wire m_p1 = char_match(I_RX_DATA, pause1, wlen);
	wire m_p2 = char_match(I_RX_DATA, pause2, wlen);
	wire m_r1 = char_match(I_RX_DATA, resume1, wlen);
	wire m_r2 = char_match(I_RX_DATA, resume2, wlen);

	reg hold_v_reg;
	reg hold_v_next;
	reg hold_off_reg;
	reg hold_off_next;
	reg [`ENTRY_W-1:0] hold_reg;
	reg [`ENTRY_W-1:0] hold_next;
	reg stage_v_reg;
	reg stage_v_next;
	reg [`ENTRY_W-1:0] stage_reg;
	reg [`ENTRY_W-1:0] stage_next;
	reg off_evt;
	reg on_evt;

	always @* begin
		hold_v_next = hold_v_reg;
		hold_off_next = hold_off_reg;
		hold_next = hold_reg;
		stage_v_next = 1'b0;
		stage_next = stage_reg;
		push = 1'b0;
		push_data = rx_entry;
		off_evt = 1'b0;
		on_evt = 1'b0;
		if (stage_v_reg) begin
			push = room;
			push_data = stage_reg;
		end
		if (accept) begin
			if (!sw_rx) begin
				push = room;
			end else if (rx_mode == `SW_CH1 || rx_mode == `SW_CH2) begin
				if (rx_mode == `SW_CH1 ? m_p1 : m_p2)
					off_evt = 1'b1;
				else if (rx_mode == `SW_CH1 ? m_r1 : m_r2)
					on_evt = 1'b1;
				else
					push = room;
			end else if (hold_v_reg && (hold_off_reg ? m_p2 : m_r2)) begin
				hold_v_next = 1'b0;
				off_evt = hold_off_reg;
				on_evt = !hold_off_reg;
			end else begin
				if (hold_v_reg) begin
					push = room;
					push_data = hold_reg;
				end
				hold_v_next = m_p1 || m_r1;
				hold_off_next = m_p1;
				hold_next = rx_entry;
				if (!(m_p1 || m_r1)) begin
					if (hold_v_reg) begin
						stage_v_next = 1'b1;
						stage_next = rx_entry;
					end else begin
						push = room;
					end
				end
			end
		end
		if (rx_mode != `SW_BOTH && !stage_v_reg && hold_v_reg) begin
			push = room;
			push_data = hold_reg;
			hold_v_next = 1'b0;
		end
	end

	always @(posedge I_CLK) begin
		if (I_SRST) begin
			hold_v_reg <= 1'b0;
			hold_off_reg <= 1'b0;
			hold_reg <= {`ENTRY_W{1'b0}};
			stage_v_reg <= 1'b0;
			stage_reg <= {`ENTRY_W{1'b0}};
		end else begin
			hold_v_reg <= hold_v_next;
			hold_off_reg <= hold_off_next;
			hold_reg <= hold_next;
			stage_v_reg <= stage_v_next;
			stage_reg <= stage_next;
		end
	end

	// Clear-to-send pin synchroniser
	reg cts_s1_reg;
	reg cts_s2_reg;
	reg cts_s3_reg;
	reg cts_lvl_reg;
	wire cts_lvl_next = (cts_s2_reg == cts_s3_reg) ? cts_s3_reg : cts_lvl_reg;

	always @(posedge I_CLK) begin
		if (I_SRST) begin
			cts_s1_reg <= 1'b0;
			cts_s2_reg <= 1'b0;
			cts_s3_reg <= 1'b0;
			cts_lvl_reg <= 1'b0;
		end else begin
			cts_s1_reg <= I_CTS_N;
			cts_s2_reg <= cts_s1_reg;
			cts_s3_reg <= cts_s2_reg;
			cts_lvl_reg <= cts_lvl_next;
		end
	end

	// Auto RTS and RS-485 direction
	reg rts_halt_reg;
	reg rts_halt_next;
	reg dir_tx_reg;
	reg dir_tx_next;
	reg rts_n_next;

	always @* begin
		rts_halt_next = rts_halt_reg;
		if (!enhanced_feature_reg[`EFR_ARTS])
			rts_halt_next = 1'b0;
		else if (at_halt && count != {`FIFO_CW{1'b0}})
			rts_halt_next = 1'b1;
		else if (at_resume)
			rts_halt_next = 1'b0;
		dir_tx_next = dir_tx_reg;
		if (!extra_feature_ctrl_reg[`EXTRA_FEATURE_CTRL_REG_485])
			dir_tx_next = 1'b0;
		else if (I_TX_PENDING)
			dir_tx_next = 1'b1;
		else if (I_TX_CHAR_DONE)
			dir_tx_next = 1'b0;
		if (extra_feature_ctrl_reg[`EXTRA_FEATURE_CTRL_REG_485])
			rts_n_next = !dir_tx_reg ^ extra_feature_ctrl_reg[`EXTRA_FEATURE_CTRL_REG_485INV];
		else
			rts_n_next = !I_MODEM_CONTROL_REG[`MCR_RTS] ||
				(enhanced_feature_reg[`EFR_ARTS] && rts_halt_reg);
	end

	// Flow character sender
	reg [2:0] st_reg;
	reg [2:0] st_next;
	reg send_off_reg;
	reg send_off_next;
	reg sent_off_reg;
	reg sent_off_next;
	reg [1:0] sel;

	always @* begin
		st_next = st_reg;
		send_off_next = send_off_reg;
		sent_off_next = sent_off_reg;
		case (st_reg)
		`ST_IDLE: begin
			if (tx_mode == `SW_NONE) begin
				sent_off_next = 1'b0;
			end else if (!sent_off_reg && at_halt &&
				count != {`FIFO_CW{1'b0}}) begin
				st_next = `ST_FIRST;
				send_off_next = 1'b1;
				sent_off_next = 1'b1;
			end else if (sent_off_reg && at_resume) begin
				st_next = `ST_FIRST;
				send_off_next = 1'b0;
				sent_off_next = 1'b0;
			end
		end
		`ST_FIRST: begin
			if (I_TX_FC_ACK)
				st_next = (tx_mode == `SW_BOTH) ? `ST_SECOND : `ST_IDLE;
		end
		`ST_SECOND: begin
			if (I_TX_FC_ACK)
				st_next = `ST_IDLE;
		end
		default: st_next = `ST_IDLE;
		endcase
		if (st_next == `ST_SECOND || tx_mode == `SW_CH2)
			sel = {send_off_next, 1'b1};
		else
			sel = {send_off_next, 1'b0};
	end

	// Flags, halt state and registered outputs
	reg xoff_halt_reg;
	wire xoff_halt_next = off_evt ? 1'b1 : (on_evt ? 1'b0 : xoff_halt_reg);
	wire enh = enhanced_feature_reg[`EFR_ENH];
	wire rts_rise = rts_n_next && !O_RTS_N && interrupt_enable_reg[`IER_RTS] && enh;
	wire cts_rise = cts_lvl_next && !cts_lvl_reg && interrupt_enable_reg[`IER_CTS] && enh;
	wire x_set = interrupt_enable_reg[`IER_XOFF] && (off_evt || (accept && scd_hit));
	wire isr_flow_next = rts_rise || cts_rise || (O_ISR_FLOW && !I_ISR_READ);
	wire isr_xoff_next = x_set ||
		(O_ISR_XOFF && !on_evt && !I_ISR_READ);
	wire tx_ok = !(enhanced_feature_reg[`EFR_ACTS] && cts_lvl_next) &&
		!xoff_halt_next &&
		!(extra_feature_ctrl_reg[`EXTRA_FEATURE_CTRL_REG_485] && !dir_tx_reg) &&
		(st_next == `ST_IDLE);

	always @(posedge I_CLK) begin
		if (I_SRST) begin
			rts_halt_reg <= 1'b0;
			dir_tx_reg <= 1'b0;
			st_reg <= `ST_IDLE;
			send_off_reg <= 1'b0;
			sent_off_reg <= 1'b0;
			xoff_halt_reg <= 1'b0;
			O_RX_HOLDING_REG <= 8'h00;
			O_LINE_STATUS_ERR <= 3'h0;
			O_DATA_READY <= 1'b0;
			O_RX_LEVEL <= 7'h00;
			O_RTS_N <= 1'b1;
			O_TX_ALLOW <= 1'b0;
			O_TX_FC_REQ <= 1'b0;
			O_TX_FC_CHAR <= 8'h00;
			O_ISR_FLOW <= 1'b0;
			O_ISR_XOFF <= 1'b0;
			O_IRQ <= 1'b0;
		end else begin
			rts_halt_reg <= rts_halt_next;
			dir_tx_reg <= dir_tx_next;
			st_reg <= st_next;
			send_off_reg <= send_off_next;
			sent_off_reg <= sent_off_next;
			xoff_halt_reg <= xoff_halt_next;
			O_RX_HOLDING_REG <= head[7:0];
			O_LINE_STATUS_ERR <= (count != {`FIFO_CW{1'b0}}) ?
				head[`ENTRY_W-1:8] : 3'h0;
			O_DATA_READY <= (count != {`FIFO_CW{1'b0}});
			O_RX_LEVEL <= count;
			O_RTS_N <= rts_n_next;
			O_TX_ALLOW <= tx_ok;
			O_TX_FC_REQ <= (st_next != `ST_IDLE);
			O_TX_FC_CHAR <= char_reg[sel];
			O_ISR_FLOW <= isr_flow_next;
			O_ISR_XOFF <= isr_xoff_next;
			O_IRQ <= isr_flow_next || isr_xoff_next;
		end
	end
endmodule // uart_rx_flow_control

`default_nettype wire

// >>> verif/uart_rx_fc_asserts.sv
// Checker of the receive path and flow control outputs.
// Assumes binding onto the top module ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_fc_asserts (
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic I_CTS_N,
	input wire logic I_TX_FC_ACK,
	input wire logic [7:0] I_ENHANCED_FEATURE_REG,
	input wire logic [7:0] I_EXTRA_FEATURE_CTRL_REG,
	input wire logic [7:0] I_MODEM_CONTROL_REG,
	input wire logic [7:0] I_INTERRUPT_ENABLE_REG,
	input wire logic [7:0] I_TRIGGER_CONTROL_REG,
	input wire logic [2:0] O_LINE_STATUS_ERR,
	input wire logic O_DATA_READY,
	input wire logic [6:0] O_RX_LEVEL,
	input wire logic O_RTS_N,
	input wire logic O_TX_ALLOW,
	input wire logic O_TX_FC_REQ,
	input wire logic [7:0] O_TX_FC_CHAR,
	input wire logic O_ISR_FLOW,
	input wire logic O_ISR_XOFF,
	input wire logic O_IRQ
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_SRST);
	property p_step;
		!$past(I_SRST) && O_RX_LEVEL != $past(O_RX_LEVEL) |->
			O_RX_LEVEL - $past(O_RX_LEVEL) == 7'h01 || $past(O_RX_LEVEL) - O_RX_LEVEL == 7'h01;
	endproperty
	a_step: assert property (p_step) else $error("level jumped");
	property p_empty_tags;
		!O_DATA_READY |-> O_LINE_STATUS_ERR == 3'h0 && O_RX_LEVEL == 7'h00;
	endproperty
	a_empty_tags: assert property (p_empty_tags) else $error("tags while empty");
	property p_rts_halt;
		I_ENHANCED_FEATURE_REG[6] && I_MODEM_CONTROL_REG[1] && !I_EXTRA_FEATURE_CTRL_REG[4]
			&& I_TRIGGER_CONTROL_REG[3:0] != 4'h0
			&& O_RX_LEVEL >= {1'b0, I_TRIGGER_CONTROL_REG[3:0], 2'h0} |-> ##[0:3] O_RTS_N;
	endproperty
	a_rts_halt: assert property (p_rts_halt) else $error("no halt at level");
	property p_rts_flag;
		$rose(O_RTS_N) && I_INTERRUPT_ENABLE_REG[6] && I_ENHANCED_FEATURE_REG[4] |-> ##[0:2] O_ISR_FLOW;
	endproperty
	a_rts_flag: assert property (p_rts_flag) else $error("no flag on rts rise");
	property p_irq;
		O_IRQ == (O_ISR_FLOW || O_ISR_XOFF);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");
	property p_cts_stop;
		(I_ENHANCED_FEATURE_REG[7] && I_CTS_N) [*8] |-> !O_TX_ALLOW;
	endproperty
	a_cts_stop: assert property (p_cts_stop) else $error("sending while cts high");
	property p_cts_flag;
		$rose(I_CTS_N) && I_INTERRUPT_ENABLE_REG[7] && I_ENHANCED_FEATURE_REG[4] |-> ##[2:10] O_ISR_FLOW;
	endproperty
	a_cts_flag: assert property (p_cts_flag) else $error("no flag on cts");
	property p_fc_hold;
		O_TX_FC_REQ && !I_TX_FC_ACK |=> O_TX_FC_REQ && $stable(O_TX_FC_CHAR);
	endproperty
	a_fc_hold: assert property (p_fc_hold) else $error("flow char dropped");
endmodule // uart_rx_fc_asserts
bind uart_rx_flow_control uart_rx_fc_asserts chk_u (.*);
`default_nettype wire

// >>> verif/remote_uart_model.sv
// Remote station: sends characters, takes flow characters.
// Assumes calls one nanosecond after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module remote_uart_model (
	input wire logic i_clk,
	input wire logic i_fc_req,
	input wire logic [7:0] i_fc_char,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_par,
	output logic [2:0] o_rx_err,
	output logic o_fc_ack
);
	int lag = 0;
	logic [7:0] got [$];
	// Sends regardless of the request line
	task automatic send(input logic [7:0] d, input logic p, input logic [2:0] e);
		o_rx_valid = 1'b1;
		o_rx_data = d;
		o_rx_par = p;
		o_rx_err = e;
		@(posedge i_clk);
		#1;
		o_rx_valid = 1'b0;
		o_rx_data = ~d;
		o_rx_par = ~p;
		o_rx_err = ~e;
	endtask
	initial begin
		o_rx_valid = 1'b0;
		o_rx_data = 8'h00;
		o_rx_par = 1'b0;
		o_rx_err = 3'h0;
		o_fc_ack = 1'b0;
		forever begin
			@(posedge i_clk);
			#1;
			if (i_fc_req) begin
				repeat (lag) @(posedge i_clk);
				#1;
				o_fc_ack = 1'b1;
				got.push_back(i_fc_char);
				@(posedge i_clk);
				#1;
				o_fc_ack = 1'b0;
			end
		end
	end
endmodule // remote_uart_model
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench of the receive path and flow control.
// Assumes the remote station model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic I_CLK, I_SRST, I_RX_VALID, I_RX_PARITY_BIT, I_RX_ENABLE, I_RHR_READ, I_ISR_READ, I_CHAR_WE;
	logic [7:0] I_RX_DATA, I_FIFO_CONTROL_REG, I_ENHANCED_FEATURE_REG, I_EXTRA_FEATURE_CTRL_REG;
	logic [7:0] I_MODEM_CONTROL_REG, I_INTERRUPT_ENABLE_REG, I_TRIGGER_CONTROL_REG, I_LINE_CONTROL_REG;
	logic [7:0] I_CHAR_WDATA, O_RX_HOLDING_REG, O_TX_FC_CHAR;
	logic [3:0] I_SWFC_MODE;
	logic [2:0] I_RX_ERR, O_LINE_STATUS_ERR;
	logic [1:0] I_CHAR_SEL;
	logic [6:0] O_RX_LEVEL;
	logic I_CTS_N, I_TX_PENDING, I_TX_CHAR_DONE, I_TX_FC_ACK, O_DATA_READY, O_RTS_N;
	logic O_TX_ALLOW, O_TX_FC_REQ, O_ISR_FLOW, O_ISR_XOFF, O_IRQ;
	int err_total = 0;
	int n_tests = 0;
	uart_rx_flow_control dut_u (.*);
	remote_uart_model rem_u (.i_clk(I_CLK), .i_fc_req(O_TX_FC_REQ), .i_fc_char(O_TX_FC_CHAR),
		.o_rx_valid(I_RX_VALID), .o_rx_data(I_RX_DATA), .o_rx_par(I_RX_PARITY_BIT),
		.o_rx_err(I_RX_ERR), .o_fc_ack(I_TX_FC_ACK));
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge I_CLK);
		#1;
	endtask
	task automatic snd(input logic [7:0] d, input logic p, input logic [2:0] e);
		rem_u.send(d, p, e);
		w(2);
	endtask
	task automatic rd();
		I_RHR_READ = 1'b1;
		w(1);
		I_RHR_READ = 1'b0;
		w(2);
	endtask
	task automatic clr();
		I_ISR_READ = 1'b1;
		w(1);
		I_ISR_READ = 1'b0;
		w(1);
	endtask
	task automatic wch(input logic [1:0] s, input logic [7:0] d);
		I_CHAR_WE = 1'b1;
		I_CHAR_SEL = s;
		I_CHAR_WDATA = d;
		w(1);
		I_CHAR_WE = 1'b0;
		w(1);
	endtask
	task automatic t_fifo();
		snd(8'ha1, 1'b0, 3'h1);
		snd(8'hb2, 1'b0, 3'h6);
		chk("head", O_RX_HOLDING_REG, 8'ha1);
		chk("tags", O_LINE_STATUS_ERR, 3'h1);
		rd();
		chk("next head", O_RX_HOLDING_REG, 8'hb2);
		chk("next tags", O_LINE_STATUS_ERR, 3'h6);
		rd();
		for (int i = 0; i < 66; i++) snd(i[7:0], 1'b0, 3'h0);
		chk("full", O_RX_LEVEL, 8'h40);
		for (int i = 0; i < 64; i++) begin
			chk("order", O_RX_HOLDING_REG, i[7:0]);
			rd();
		end
		chk("empty", {O_DATA_READY, O_LINE_STATUS_ERR}, 8'h00);
		I_FIFO_CONTROL_REG = 8'h00;
		snd(8'hc5, 1'b0, 3'h0);
		snd(8'hc6, 1'b0, 3'h0);
		chk("single level", O_RX_LEVEL, 8'h01);
		chk("single head", O_RX_HOLDING_REG, 8'hc5);
		rd();
		I_FIFO_CONTROL_REG = 8'h01;
	endtask
	task automatic t_rts();
		I_TRIGGER_CONTROL_REG = 8'h12;
		I_ENHANCED_FEATURE_REG = 8'h50;
		I_INTERRUPT_ENABLE_REG = 8'h40;
		I_MODEM_CONTROL_REG = 8'h02;
		repeat (7) snd(8'h55, 1'b0, 3'h0);
		chk("rts below halt", O_RTS_N, 1'b0);
		repeat (2) snd(8'h56, 1'b0, 3'h0);
		chk("rts halt", O_RTS_N, 1'b1);
		chk("rts flag", O_ISR_FLOW, 1'b1);
		chk("kept", O_RX_LEVEL, 8'h09);
		repeat (4) rd();
		chk("rts hold", O_RTS_N, 1'b1);
		rd();
		chk("rts resume", O_RTS_N, 1'b0);
		repeat (4) rd();
		clr();
		I_ENHANCED_FEATURE_REG = 8'h00;
		I_INTERRUPT_ENABLE_REG = 8'h00;
	endtask
	task automatic t_sw();
		I_SWFC_MODE = 4'h1;
		snd(8'h00, 1'b0, 3'h0);
		chk("reset char", O_RX_LEVEL, 8'h00);
		wch(2'h0, 8'h11);
		wch(2'h1, 8'h12);
		wch(2'h2, 8'h13);
		wch(2'h3, 8'h14);
		I_SWFC_MODE = 4'h3;
		I_LINE_CONTROL_REG = 8'h00;
		I_INTERRUPT_ENABLE_REG = 8'h20;
		snd(8'hf3, 1'b0, 3'h0);
		snd(8'hf4, 1'b0, 3'h0);
		chk("off dropped", O_RX_LEVEL, 8'h00);
		chk("off flag", O_IRQ, 1'b1);
		chk("off stop", O_TX_ALLOW, 1'b0);
		snd(8'h11, 1'b0, 3'h0);
		snd(8'h12, 1'b0, 3'h0);
		chk("on clear", O_ISR_XOFF, 1'b0);
		chk("on go", O_TX_ALLOW, 1'b1);
		snd(8'h13, 1'b0, 3'h0);
		snd(8'h77, 1'b0, 3'h0);
		w(1);
		chk("unpaired", O_RX_LEVEL, 8'h02);
		chk("unpaired head", O_RX_HOLDING_REG, 8'h13);
		rd();
		rd();
		I_SWFC_MODE = 4'h0;
		I_ENHANCED_FEATURE_REG = 8'h20;
		snd(8'hf4, 1'b0, 3'h0);
		chk("special kept", O_RX_HOLDING_REG, 8'hf4);
		chk("special flag", O_ISR_XOFF, 1'b1);
		rd();
		clr();
		I_ENHANCED_FEATURE_REG = 8'h00;
		I_LINE_CONTROL_REG = 8'h03;
	endtask
	task automatic t_txfc();
		I_SWFC_MODE = 4'hc;
		I_TRIGGER_CONTROL_REG = 8'h01;
		rem_u.lag = 5;
		repeat (4) snd(8'h20, 1'b0, 3'h0);
		w(30);
		repeat (4) rd();
		w(30);
		chk("pause1", rem_u.got[0], 8'h13);
		chk("pause2", rem_u.got[1], 8'h14);
		chk("resume1", rem_u.got[2], 8'h11);
		chk("resume2", rem_u.got[3], 8'h12);
		I_SWFC_MODE = 4'h0;
	endtask
	task automatic t_pins();
		I_ENHANCED_FEATURE_REG = 8'h90;
		I_INTERRUPT_ENABLE_REG = 8'h80;
		I_CTS_N = 1'b1;
		w(10);
		chk("cts stop", O_TX_ALLOW, 1'b0);
		chk("cts flag", O_ISR_FLOW, 1'b1);
		I_CTS_N = 1'b0;
		w(10);
		chk("cts go", O_TX_ALLOW, 1'b1);
		clr();
		I_ENHANCED_FEATURE_REG = 8'h00;
		I_TX_PENDING = 1'b0;
		I_EXTRA_FEATURE_CTRL_REG = 8'h10;
		w(3);
		chk("dir idle", O_RTS_N, 1'b1);
		I_TX_PENDING = 1'b1;
		w(3);
		chk("dir send", {O_RTS_N, O_TX_ALLOW}, 8'h01);
		I_TX_PENDING = 1'b0;
		w(3);
		chk("dir hold", O_RTS_N, 1'b0);
		I_TX_CHAR_DONE = 1'b1;
		w(1);
		I_TX_CHAR_DONE = 1'b0;
		w(2);
		chk("dir back", O_RTS_N, 1'b1);
		I_EXTRA_FEATURE_CTRL_REG = 8'h30;
		w(3);
		chk("dir invert", O_RTS_N, 1'b0);
		I_EXTRA_FEATURE_CTRL_REG = 8'h01;
		I_LINE_CONTROL_REG = 8'h3b;
		I_RX_ENABLE = 1'b0;
		snd(8'h33, 1'b0, 3'h0);
		snd(8'h42, 1'b1, 3'h0);
		chk("addr only", O_RX_LEVEL, 8'h01);
		chk("addr tag", O_LINE_STATUS_ERR, 3'h1);
		rd();
		I_RX_ENABLE = 1'b1;
		snd(8'h34, 1'b0, 3'h0);
		chk("data kept", O_RX_HOLDING_REG, 8'h34);
	endtask
	task automatic results();
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		I_CLK = 1'b0;
		forever #2.5 I_CLK = ~I_CLK;
	end
	initial begin
		#200000;
		err_total++;
		results();
	end
	initial begin
		{I_RHR_READ, I_ISR_READ, I_CHAR_WE, I_CHAR_SEL, I_CHAR_WDATA, I_TX_CHAR_DONE} = '0;
		{I_ENHANCED_FEATURE_REG, I_EXTRA_FEATURE_CTRL_REG, I_MODEM_CONTROL_REG} = '0;
		{I_INTERRUPT_ENABLE_REG, I_TRIGGER_CONTROL_REG, I_SWFC_MODE, I_CTS_N} = '0;
		I_FIFO_CONTROL_REG = 8'h01;
		I_LINE_CONTROL_REG = 8'h03;
		I_RX_ENABLE = 1'b1;
		I_TX_PENDING = 1'b1;
		I_SRST = 1'b1;
		w(16);
		I_SRST = 1'b0;
		w(2);
		t_fifo();
		t_rts();
		t_sw();
		t_txfc();
		t_pins();
		results();
	end
endmodule // tb
`default_nettype wire
